//--- inc/cswc_pkg.sv
// Constants, field layouts and carrier types of the clock, sleep and watchdog setup block
package cswc_pkg;

  // ==========================================================================
  // Clock rate
  // ==========================================================================
  localparam int unsigned CLK_HZ = 50_000_000; // System clock rate
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000; // Cycles per us
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1_000; // Cycles per ms

  // ==========================================================================
  // Register indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [9:0] IDX_SETUP = 10'h0a8; // clock_sleep_watchdog_setup
  localparam logic [9:0] IDX_PERI = 10'h0aa; // peripheral_setup_one
  localparam logic [9:0] IDX_STATUS = 10'h0ac; // Sticky event status, RO
  localparam logic [9:0] IDX_CLEAR = 10'h0ad; // Event clear, WO, write 1
  localparam logic [9:0] IDX_ENABLE = 10'h0ae; // Interrupt enable, RW
  localparam logic [9:0] IDX_STATE = 10'h0af; // Live block state, RO

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [31:0] RST_SETUP = 32'h0000_0000; // Setup word reset
  localparam logic [31:0] RST_PERI = 32'h0400_0000; // Peripheral word reset
  localparam logic [31:0] SETUP_WMASK = 32'h7fff_ffff; // Bit 31 reserved

  // ==========================================================================
  // Field positions of the setup word
  // ==========================================================================
  localparam int unsigned POS_MAX_FREQ = 16; // Full-scale frequency, 30:16
  localparam int unsigned POS_SLEEP_TIME = 14; // Sleep entry time, 15:14
  localparam int unsigned POS_CUR_GAIN = 13; // auto_current_gain_on
  localparam int unsigned POS_VOLT_GAIN = 12; // auto_volt_gain_on
  localparam int unsigned POS_LP_SEL = 11; // low_power_state_select
  localparam int unsigned POS_CLK_SRC = 9; // Clock source, 10:9
  localparam int unsigned POS_TB_ON = 8; // outside_timebase_on
  localparam int unsigned POS_TB_RATE = 5; // outside_timebase_rate, 7:5
  localparam int unsigned POS_WDT_ON = 4; // host_watchdog_on
  localparam int unsigned POS_WDT_INT = 2; // host_watchdog_interval, 3:2
  localparam int unsigned POS_WDT_SRC = 1; // host_watchdog_source
  localparam int unsigned POS_WDT_ACT = 0; // host_watchdog_action

  // Setup word, packed in bit order from 31 down to 0
  typedef struct packed {
    logic reserved31; // Always zero
    logic [14:0] max_freq; // Frequency meaning full duty
    logic [1:0] sleep_time; // Sleep entry time code
    logic auto_current_gain_on; // Current sense amp auto gain
    logic auto_volt_gain_on; // Voltage auto gain
    logic low_power_state_select; // 0 standby, 1 sleep
    logic [1:0] clk_source; // 0 internal, 3 external
    logic outside_timebase_on; // External clock mode enable
    logic [2:0] outside_timebase_rate; // External reference rate code
    logic host_watchdog_on; // Watchdog supervision enable
    logic [1:0] host_watchdog_interval; // Tickle interval code
    logic host_watchdog_source; // 0 bus tickle, 1 pin tickle
    logic host_watchdog_action; // 0 report, 1 latch and Hi-Z
  } cswc_setup_t;

  // ==========================================================================
  // Codes
  // ==========================================================================
  localparam logic [1:0] SPEED_FREQ_MODE = 2'h3; // Speed from pin frequency
  localparam logic [1:0] CLK_SRC_EXT = 2'h3; // External clock input
  localparam logic [10:0] TB_BASE_KHZ = 11'h008; // Rate code 0 is 8 kHz
  localparam int unsigned EV_SLEEP = 0; // Event bit: low-power entry
  localparam int unsigned EV_WDT = 1; // Event bit: watchdog fault
  localparam int unsigned ST_LP = 16; // State bit: low power active
  localparam int unsigned ST_HIZ = 17; // State bit: outputs Hi-Z
  localparam int unsigned ST_DVAL = 18; // State bit: duty valid

  // ==========================================================================
  // Times and derived cycle counts
  // ==========================================================================
  localparam int unsigned SLEEP_T0_US = 50; // Sleep code 0
  localparam int unsigned SLEEP_T1_US = 200; // Sleep code 1
  localparam int unsigned SLEEP_T2_MS = 20; // Sleep code 2
  localparam int unsigned SLEEP_T3_MS = 200; // Sleep code 3
  localparam int unsigned WDT_PIN_T0_MS = 100; // Pin tickle code 0
  localparam int unsigned WDT_PIN_T1_MS = 200; // Pin tickle code 1
  localparam int unsigned WDT_PIN_T2_MS = 500; // Pin tickle code 2
  localparam int unsigned WDT_PIN_T3_MS = 1000; // Pin tickle code 3
  localparam int unsigned WDT_BUS_T0_S = 1; // Bus tickle code 0
  localparam int unsigned WDT_BUS_T1_S = 2; // Bus tickle code 1
  localparam int unsigned WDT_BUS_T2_S = 3; // Bus tickle code 2
  localparam int unsigned WDT_BUS_T3_S = 10; // Bus tickle code 3
  localparam int unsigned SLEEP_C0 = SLEEP_T0_US * CLK_PER_US;
  localparam int unsigned SLEEP_C1 = SLEEP_T1_US * CLK_PER_US;
  localparam int unsigned SLEEP_C2 = SLEEP_T2_MS * CLK_PER_MS;
  localparam int unsigned SLEEP_C3 = SLEEP_T3_MS * CLK_PER_MS;
  localparam int unsigned WDT_PIN_C0 = WDT_PIN_T0_MS * CLK_PER_MS;
  localparam int unsigned WDT_PIN_C1 = WDT_PIN_T1_MS * CLK_PER_MS;
  localparam int unsigned WDT_PIN_C2 = WDT_PIN_T2_MS * CLK_PER_MS;
  localparam int unsigned WDT_PIN_C3 = WDT_PIN_T3_MS * CLK_PER_MS;
  localparam int unsigned WDT_BUS_C0 = WDT_BUS_T0_S * CLK_HZ;
  localparam int unsigned WDT_BUS_C1 = WDT_BUS_T1_S * CLK_HZ;
  localparam int unsigned WDT_BUS_C2 = WDT_BUS_T2_S * CLK_HZ;
  localparam int unsigned WDT_BUS_C3 = WDT_BUS_T3_S * CLK_HZ;

  // ==========================================================================
  // Divider and bus carriers
  // ==========================================================================
  typedef enum logic [1:0] {
    DIV_IDLE = 2'b00, // Waiting to start
    DIV_RUN = 2'b01, // Shifting quotient bits
    DIV_DONE = 2'b11 // Result ready to publish
  } cswc_div_t;

  typedef struct packed {
    logic psel; // Slave select
    logic penable; // Access phase
    logic pwrite; // Write when high
    logic [11:0] paddr; // Byte address
    logic [31:0] pwdata; // Write data
    logic [3:0] pstrb; // Write byte lanes
  } cswc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata; // Read data
    logic pready; // Transfer done
    logic pslverr; // Unmapped address
  } cswc_apb_rsp_t;

endpackage : cswc_pkg

//--- hdl/cswc_timeout.sv
// Restartable cycle counter that pulses when a run interval expires
`timescale 1ns/1ps
module cswc_timeout
  import cswc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic [31:0] i_limit,
  output logic o_expired
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [31:0] cnt; // Cycles spent running
    logic expired; // One-cycle expiry pulse
  } cswc_tmo_state_t;

  cswc_tmo_state_t s; // Registered state
  cswc_tmo_state_t next_s; // Next state

  // Count while running, restart on any pause or on expiry
  always_comb begin
    next_s = s;
    next_s.expired = 1'b0;
    if (!i_run) begin
      next_s.cnt = 32'h0;
    end else if (s.cnt + 32'h1 >= i_limit) begin
      next_s.cnt = 32'h0;
      next_s.expired = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 32'h1;
    end
  end

  // Register the state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_expired = s.expired;

endmodule : cswc_timeout

//--- hdl/cswc_top.sv
// Clock, sleep and watchdog setup register bank with its control logic
//
// Functional notes
// - Setup word at A8h, resets zero, bit31 zero
// - Frequency mode duty is input over full-scale
// - Frequency duty only when speed source is 3
// - Sleep after low speed for coded time
// - Bit 13 enables automatic current gain
// - Bit 12 enables automatic voltage gain
// - Bit 11 picks standby or sleep state
// - Clock source code 0 internal, 3 external
// - External clock mode only while bit 8 set
// - Bits 7-5 declare reference, 8 to 1024 kHz
// - Watchdog supervised only while bit 4 set
// - Host tickles within coded interval per source
// - Bit 1 picks bus or pin tickle source
// - Fault reported, or latched with outputs Hi-Z
`timescale 1ns/1ps
module cswc_top
  import cswc_pkg::*;
#(
  parameter int unsigned P_SLEEP_C1 = SLEEP_C1, // 200 us
  parameter int unsigned P_SLEEP_C2 = SLEEP_C2, // 20 ms
  parameter int unsigned P_SLEEP_C3 = SLEEP_C3, // 200 ms
  parameter int unsigned P_WDT_PIN_C0 = WDT_PIN_C0, // 100 ms
  parameter int unsigned P_WDT_PIN_C1 = WDT_PIN_C1, // 200 ms
  parameter int unsigned P_WDT_PIN_C2 = WDT_PIN_C2, // 500 ms
  parameter int unsigned P_WDT_PIN_C3 = WDT_PIN_C3, // 1000 ms
  parameter int unsigned P_WDT_BUS_C0 = WDT_BUS_C0, // 1 s
  parameter int unsigned P_WDT_BUS_C1 = WDT_BUS_C1, // 2 s
  parameter int unsigned P_WDT_BUS_C2 = WDT_BUS_C2, // 3 s
  parameter int unsigned P_WDT_BUS_C3 = WDT_BUS_C3 // 10 s
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire cswc_apb_req_t i_apb,
  output cswc_apb_rsp_t o_apb,
  input wire logic [1:0] i_speed_mode,
  input wire logic [15:0] i_meas_freq,
  input wire logic i_speed_low,
  input wire logic i_tickle_bus,
  input wire logic i_tickle_pin,
  output logic [15:0] o_duty,
  output logic o_duty_valid,
  output logic o_auto_current_gain_on,
  output logic o_auto_volt_gain_on,
  output logic o_standby,
  output logic o_sleep,
  output logic o_use_ext_clk,
  output logic [10:0] o_ref_khz,
  output logic o_wdt_fault,
  output logic o_fet_hiz,
  output logic o_irq
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    cswc_setup_t setup; // Setup word
    logic [31:0] peri; // Peripheral word, stored only
    logic [1:0] status; // Sticky events
    logic [1:0] irq_en; // Interrupt enables
    logic [31:0] prdata; // Read data, caught at setup phase
    cswc_div_t div; // Divider phase
    logic [4:0] div_cnt; // Remaining quotient bits
    logic [16:0] div_rem; // Partial remainder
    logic [15:0] div_q; // Quotient being built
    logic [15:0] duty; // Published duty
    logic duty_valid; // Duty follows the input
    logic low_power; // Low-power state active
    logic standby; // Active state is standby
    logic sleep; // Active state is sleep
    logic hiz; // Latched watchdog fault
    logic wdt_fault; // One-cycle fault pulse
    logic pin_prev; // Tickle pin, last cycle
    logic use_ext; // External clock in use
    logic [10:0] ref_khz; // Declared reference rate
  } cswc_state_t;

  cswc_state_t s; // Registered state
  cswc_state_t next_s; // Next state

  logic [9:0] idx; // Word index of the bus address
  logic hit; // Address is mapped
  logic [31:0] rd_word; // Read mux
  logic [31:0] sleep_limit; // Selected sleep time in cycles
  logic [31:0] wdt_limit; // Selected tickle interval in cycles
  logic sleep_run; // Sleep timer runs
  logic sleep_exp; // Sleep timer expired
  logic wdt_run; // Watchdog timer runs
  logic wdt_exp; // Watchdog timer expired
  logic tickle; // Tickle from the chosen source

  // Merge write data into a word by byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ==========================================================================
  // Address decode and read mux
  // ==========================================================================
  always_comb begin
    idx = i_apb.paddr[11:2];
    hit = 1'b1;
    rd_word = 32'h0;
    case (idx)
      IDX_SETUP: begin
        rd_word = s.setup & SETUP_WMASK;
      end
      IDX_PERI: begin
        rd_word = s.peri;
      end
      IDX_STATUS: begin
        rd_word = {30'h0, s.status};
      end
      IDX_CLEAR: begin
        rd_word = 32'h0; // Write-only, reads zero
      end
      IDX_ENABLE: begin
        rd_word = {30'h0, s.irq_en};
      end
      IDX_STATE: begin
        rd_word = {13'h0, s.duty_valid, s.hiz, s.low_power, s.duty};
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Timer selection
  // ==========================================================================
  always_comb begin
    case (s.setup.sleep_time)
      2'h0: sleep_limit = SLEEP_C0;
      2'h1: sleep_limit = P_SLEEP_C1;
      2'h2: sleep_limit = P_SLEEP_C2;
      default: sleep_limit = P_SLEEP_C3;
    endcase
    if (s.setup.host_watchdog_source) begin
      case (s.setup.host_watchdog_interval)
        2'h0: wdt_limit = P_WDT_PIN_C0;
        2'h1: wdt_limit = P_WDT_PIN_C1;
        2'h2: wdt_limit = P_WDT_PIN_C2;
        default: wdt_limit = P_WDT_PIN_C3;
      endcase
    end else begin
      case (s.setup.host_watchdog_interval)
        2'h0: wdt_limit = P_WDT_BUS_C0;
        2'h1: wdt_limit = P_WDT_BUS_C1;
        2'h2: wdt_limit = P_WDT_BUS_C2;
        default: wdt_limit = P_WDT_BUS_C3;
      endcase
    end
    // Pin tickles count on the rising edge, bus tickles as pulses
    tickle = s.setup.host_watchdog_source ?
             (i_tickle_pin & ~s.pin_prev) : i_tickle_bus;
    sleep_run = i_speed_low & ~s.low_power;
    wdt_run = s.setup.host_watchdog_on & ~tickle;
  end

  // Sleep entry timer
  cswc_timeout u_sleep_tmo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_run(sleep_run),
    .i_limit(sleep_limit),
    .o_expired(sleep_exp)
  );

  // Host watchdog timer
  cswc_timeout u_wdt_tmo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_run(wdt_run),
    .i_limit(wdt_limit),
    .o_expired(wdt_exp)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_s = s;
    next_s.pin_prev = i_tickle_pin;
    next_s.wdt_fault = 1'b0;

    // Read data is caught in the setup phase, stable through access
    if (i_apb.psel && !i_apb.penable && !i_apb.pwrite) begin
      next_s.prdata = rd_word;
    end

    // Register writes take effect at the access edge
    if (i_apb.psel && i_apb.penable && i_apb.pwrite && hit) begin
      case (idx)
        IDX_SETUP: begin
          next_s.setup = merge(s.setup, i_apb.pwdata, i_apb.pstrb)
                         & SETUP_WMASK;
        end
        IDX_PERI: begin
          next_s.peri = merge(s.peri, i_apb.pwdata, i_apb.pstrb);
        end
        IDX_CLEAR: begin
          if (i_apb.pstrb[0]) begin
            next_s.status = s.status & ~i_apb.pwdata[1:0];
            if (i_apb.pwdata[EV_WDT]) begin
              next_s.hiz = 1'b0;
            end
          end
        end
        IDX_ENABLE: begin
          if (i_apb.pstrb[0]) begin
            next_s.irq_en = i_apb.pwdata[1:0];
          end
        end
        default: begin
          next_s.setup = s.setup;
        end
      endcase
    end

    // Low-power entry and wake, event set wins over a clear
    if (sleep_exp) begin
      next_s.low_power = 1'b1;
      next_s.standby = ~s.setup.low_power_state_select;
      next_s.sleep = s.setup.low_power_state_select;
      next_s.status[EV_SLEEP] = 1'b1;
    end else if (!i_speed_low) begin
      next_s.low_power = 1'b0;
      next_s.standby = 1'b0;
      next_s.sleep = 1'b0;
    end

    // Missed tickle raises a fault, latched only in latch mode
    if (wdt_exp && s.setup.host_watchdog_on) begin
      next_s.wdt_fault = 1'b1;
      next_s.status[EV_WDT] = 1'b1;
      if (s.setup.host_watchdog_action) begin
        next_s.hiz = 1'b1;
      end
    end

    // Clock selection and declared reference
    next_s.use_ext = (s.setup.clk_source == CLK_SRC_EXT) &&
                     s.setup.outside_timebase_on;
    next_s.ref_khz = TB_BASE_KHZ << s.setup.outside_timebase_rate;

    // Duty divider: quotient of input over full scale, 0.16 format
    case (s.div)
      DIV_IDLE: begin
        if (i_speed_mode == SPEED_FREQ_MODE) begin
          if (s.setup.max_freq == 15'h0 ||
              i_meas_freq >= {1'b0, s.setup.max_freq}) begin
            next_s.div_q = 16'hffff; // Saturate at full duty
            next_s.div_cnt = 5'h0;
            next_s.div = DIV_DONE;
          end else begin
            next_s.div_rem = {1'b0, i_meas_freq};
            next_s.div_q = 16'h0;
            next_s.div_cnt = 5'h10;
            next_s.div = DIV_RUN;
          end
        end else begin
          next_s.duty = 16'h0;
          next_s.duty_valid = 1'b0;
        end
      end
      DIV_RUN: begin
        // One restoring step per cycle
        if ({s.div_rem[15:0], 1'b0} >= {2'b0, s.setup.max_freq}) begin
          next_s.div_rem = {s.div_rem[15:0], 1'b0} - {2'b0, s.setup.max_freq};
          next_s.div_q = {s.div_q[14:0], 1'b1};
        end else begin
          next_s.div_rem = {s.div_rem[15:0], 1'b0};
          next_s.div_q = {s.div_q[14:0], 1'b0};
        end
        next_s.div_cnt = s.div_cnt - 5'h1;
        if (s.div_cnt == 5'h1 || i_speed_mode != SPEED_FREQ_MODE) begin
          next_s.div = DIV_DONE;
        end
      end
      DIV_DONE: begin
        next_s.duty = s.div_q;
        next_s.duty_valid = (i_speed_mode == SPEED_FREQ_MODE);
        next_s.div = DIV_IDLE;
      end
      default: begin
        next_s.div = DIV_IDLE;
      end
    endcase
  end

  // Register the state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
      s.setup <= RST_SETUP;
      s.peri <= RST_PERI;
      s.div <= DIV_IDLE;
      s.ref_khz <= TB_BASE_KHZ;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  always_comb begin
    o_apb.prdata = s.prdata;
    o_apb.pready = 1'b1;
    o_apb.pslverr = i_apb.psel & i_apb.penable & ~hit;
  end

  assign o_duty = s.duty;
  assign o_duty_valid = s.duty_valid;
  assign o_auto_current_gain_on = s.setup.auto_current_gain_on;
  assign o_auto_volt_gain_on = s.setup.auto_volt_gain_on;
  assign o_standby = s.standby;
  assign o_sleep = s.sleep;
  assign o_use_ext_clk = s.use_ext;
  assign o_ref_khz = s.ref_khz;
  assign o_wdt_fault = s.wdt_fault;
  assign o_fet_hiz = s.hiz;
  assign o_irq = |(s.status & s.irq_en);

endmodule : cswc_top

//--- sim/cswc_host_model.sv
// Host that tickles the watchdog over the bus or the pin
`timescale 1ns/1ps
module cswc_host_model
  import cswc_pkg::*;
#(
  parameter int unsigned P_GAP = 20 // Cycles between tickles
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_on,
  input wire logic i_pin_mode,
  output logic o_tickle_bus,
  output logic o_tickle_pin
);
  // ====
  // Tickle timer
  // ====
  logic [7:0] cnt; // Cycles since the last tickle
  logic due; // A tickle falls in this cycle
  assign due = i_on && (cnt == 8'(P_GAP - 1));
  // One-cycle tickle on the chosen path only
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= '0;
      o_tickle_bus <= 1'b0;
      o_tickle_pin <= 1'b0;
    end else begin
      cnt <= (due || !i_on) ? '0 : cnt + 8'h1;
      o_tickle_bus <= due && !i_pin_mode;
      o_tickle_pin <= due && i_pin_mode;
    end
  end
endmodule : cswc_host_model

//--- sim/cswc_top_chk.sv
// Port-level checks of the setup block
`timescale 1ns/1ps
module cswc_top_chk
  import cswc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire cswc_apb_req_t i_apb,
  input wire cswc_apb_rsp_t o_apb,
  input wire logic [1:0] i_speed_mode,
  input wire logic i_speed_low,
  input wire logic o_duty_valid,
  input wire logic o_auto_current_gain_on,
  input wire logic o_auto_volt_gain_on,
  input wire logic o_standby,
  input wire logic o_sleep,
  input wire logic o_use_ext_clk,
  input wire logic [10:0] o_ref_khz,
  input wire logic o_wdt_fault,
  input wire logic o_fet_hiz
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ====
  // Sequences
  // ====
  // Setup word write taken, low lanes enabled
  sequence s_set_wr;
    i_apb.psel && i_apb.penable && i_apb.pwrite &&
    i_apb.paddr == {IDX_SETUP, 2'b00} && i_apb.pstrb[1:0] == 2'b11;
  endsequence
  // Speed source away from frequency mode
  sequence s_off_mode;
    (i_speed_mode != SPEED_FREQ_MODE) [*3];
  endsequence
  // ====
  // Assertions
  // ====
  chk_err_phase: assert property (
    o_apb.pslverr |-> i_apb.psel && i_apb.penable) else $error("err");
  chk_cur_gain: assert property (
    s_set_wr |-> ##2 o_auto_current_gain_on == $past(i_apb.pwdata[13], 2))
    else $error("cur gain");
  chk_volt_gain: assert property (
    s_set_wr |-> ##2 o_auto_volt_gain_on == $past(i_apb.pwdata[12], 2))
    else $error("volt gain");
  chk_ext_mode: assert property (s_set_wr |-> ##2
    o_use_ext_clk == ($past(i_apb.pwdata[10:9], 2) == CLK_SRC_EXT &&
    $past(i_apb.pwdata[8], 2))) else $error("ext clk");
  chk_ref_rate: assert property (s_set_wr |-> ##2
    o_ref_khz == (TB_BASE_KHZ << $past(i_apb.pwdata[7:5], 2)))
    else $error("ref rate");
  chk_lp_one: assert property (
    !(o_standby && o_sleep)) else $error("both states");
  chk_lp_exit: assert property (
    !i_speed_low |=> !o_standby && !o_sleep) else $error("lp exit");
  chk_lp_entry: assert property ($rose(o_standby || o_sleep) |->
    $past(i_speed_low, 8) && $past(i_speed_low, 16)) else $error("lp in");
  chk_duty_off: assert property (
    s_off_mode |-> !o_duty_valid) else $error("duty valid");
  chk_fault_pulse: assert property (
    o_wdt_fault |=> !o_wdt_fault) else $error("fault pulse");
  chk_hiz_cause: assert property ($rose(o_fet_hiz) |->
    o_wdt_fault || $past(o_wdt_fault)) else $error("hiz cause");
endmodule : cswc_top_chk

bind cswc_top cswc_top_chk chk_u (.*);

//--- sim/testbench.sv
// Self-checking bench of the setup block
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  n_mismatch++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module testbench;
  import cswc_pkg::*;
  localparam logic [31:0] A_SET = 32'({IDX_SETUP, 2'b00}); // Setup word
  localparam logic [31:0] A_PER = 32'({IDX_PERI, 2'b00}); // Peripheral word
  localparam logic [31:0] A_STA = 32'({IDX_STATUS, 2'b00}); // Event status
  localparam logic [31:0] A_CLR = 32'({IDX_CLEAR, 2'b00}); // Event clear
  localparam logic [31:0] A_ENA = 32'({IDX_ENABLE, 2'b00}); // Event enable
  logic i_clk, i_rst, low, tk_bus, tk_pin, h_on, h_pin, err;
  logic dval, cg, vg, stby, slp, ext, flt, hiz, irq;
  logic [1:0] mode;
  logic [2:0] kk;
  logic [15:0] freq, duty;
  logic [10:0] rkhz;
  logic [31:0] rd;
  cswc_apb_req_t apb;
  cswc_apb_rsp_t rsp;
  int n_mismatch, comparisons, cyc;
  // Rows: address, write data, read-back
  logic [31:0] rows [6][3] = '{'{A_SET, 32'hffff_ffff, 32'h7fff_ffff},
    '{A_SET, 32'h1234_56e0, 32'h1234_56e0},
    '{A_PER, 32'ha5a5_5a5a, 32'ha5a5_5a5a}, '{A_STA, 32'hffff_ffff, 0},
    '{A_CLR, 32'h3, 0}, '{A_ENA, 32'h3, 32'h3}};
  cswc_top #(.P_SLEEP_C1(20), .P_WDT_PIN_C0(40),
    .P_WDT_BUS_C0(80)) dut_u (.i_clk(i_clk),
    .i_rst(i_rst), .i_apb(apb), .o_apb(rsp), .i_speed_mode(mode),
    .i_meas_freq(freq), .i_speed_low(low), .i_tickle_bus(tk_bus),
    .i_tickle_pin(tk_pin), .o_duty(duty), .o_duty_valid(dval),
    .o_auto_current_gain_on(cg), .o_auto_volt_gain_on(vg),
    .o_standby(stby), .o_sleep(slp), .o_use_ext_clk(ext),
    .o_ref_khz(rkhz), .o_wdt_fault(flt), .o_fet_hiz(hiz), .o_irq(irq));
  cswc_host_model host_u (.i_clk(i_clk), .i_rst(i_rst), .i_on(h_on),
    .i_pin_mode(h_pin), .o_tickle_bus(tk_bus), .o_tickle_pin(tk_pin));
  // ====
  // Clock, timeout and tasks
  // ====
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  // One APB transfer; holds the request until pready
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
    apb <= '{1'b1, 1'b0, w, a[11:0], d, 4'hf};
    @(posedge i_clk);
    apb.penable <= 1'b1;
    do @(posedge i_clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    apb <= '0;
    @(posedge i_clk);
  endtask : xfer
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rd_chk
  // ====
  // Main sequence
  // ====
  initial begin
    i_rst = 1'b1;
    apb = '0;
    mode = 2'h0;
    freq = 16'h0;
    low = 1'b0;
    h_on = 1'b0;
    h_pin = 1'b0;
    tick(8);
    i_rst <= 1'b0;
    tick(1);
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, rows[i][0], rows[i][1]);
      rd_chk(rows[i][0], rows[i][2]);
    end
    rd_chk(32'h2c0, 32'h0);
    `CHK(err, 1'b1)
    for (int k = 0; k < 8; k++) begin
      kk = 3'(k);
      xfer(1'b1, A_SET, {18'h0, kk[0], kk[1], 1'b0, kk[2:1], kk[0], kk,
        5'h0});
      tick(1);
      `CHK(rkhz, 11'h8 << kk)
      `CHK(ext, kk == 3'h7)
      `CHK({cg, vg}, {kk[0], kk[1]})
    end
    mode <= SPEED_FREQ_MODE;
    freq <= 16'd250;
    xfer(1'b1, A_SET, 32'h03e8_0000);
    tick(40);
    `CHK({dval, duty}, {1'b1, 16'h4000})
    freq <= 16'd1200;
    tick(20);
    `CHK(duty, 16'hffff)
    mode <= 2'h1;
    tick(5);
    `CHK({dval, duty}, 17'h0)
    xfer(1'b1, A_SET, 32'h0000_4800);
    low <= 1'b1;
    tick(15);
    `CHK(slp, 1'b0)
    tick(15);
    `CHK({slp, stby, irq}, 3'b101)
    rd_chk(A_STA, 32'h1);
    low <= 1'b0;
    tick(2);
    `CHK({slp, stby}, 2'b00)
    xfer(1'b1, A_SET, 32'h0000_4000);
    low <= 1'b1;
    tick(30);
    `CHK({slp, stby}, 2'b01)
    low <= 1'b0;
    xfer(1'b1, A_CLR, 32'h3);
    h_on <= 1'b1;
    h_pin <= 1'b1;
    xfer(1'b1, A_SET, 32'h0000_0013);
    tick(100);
    `CHK(hiz, 1'b0)
    h_on <= 1'b0;
    tick(50);
    `CHK({hiz, irq}, 2'b11)
    xfer(1'b1, A_SET, 32'h0);
    rd_chk(A_STA, 32'h2);
    xfer(1'b1, A_CLR, 32'h2);
    `CHK({hiz, irq}, 2'b00)
    h_on <= 1'b1;
    xfer(1'b1, A_SET, 32'h0000_0010);
    tick(100);
    `CHK(hiz, 1'b0)
    rd_chk(A_STA, 32'h2);
    h_pin <= 1'b0;
    xfer(1'b1, A_CLR, 32'h3);
    tick(100);
    rd_chk(A_STA, 32'h0);
    i_rst <= 1'b1;
    tick(2);
    i_rst <= 1'b0;
    tick(1);
    rd_chk(A_SET, 32'h0);
    rd_chk(A_PER, 32'h0400_0000);
    `CHK(rkhz, 11'h8)
    give_verdict();
  end
endmodule : testbench
